//--- rtl/plc_accu_pkg.sv
/*
 * Shared constants and types of the accumulator and condition code datapath.
 * Assumes a single 32-bit AHB-Lite register window and one clock domain.
 */
package plc_accu_pkg;

   localparam int unsigned ACC_W = 32;
   localparam int unsigned FIX_W = 16;
   localparam int unsigned STACK_DEPTH = 7;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_OPERAND = 8'h04;
   localparam logic [7:0] OFF_PRIMARY_OPERAND_REGISTER = 8'h08;
   localparam logic [7:0] OFF_SECONDARY_OPERAND_REGISTER = 8'h0c;
   localparam logic [7:0] OFF_ACCU3 = 8'h10;
   localparam logic [7:0] OFF_ACCU4 = 8'h14;
   localparam logic [7:0] OFF_CCB = 8'h18;
   localparam logic [7:0] OFF_XFER = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CMD_SCAN_POS = 8;
   localparam int unsigned CMD_BYTE_AREA_POS = 9;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;
   localparam logic [7:0] CC_RESET = 8'h00;
   localparam logic [31:0] MANT_TRUNC_MASK = 32'hffff_ff00;
   localparam logic [3:0] BCD_POS = 4'h0;
   localparam logic [3:0] BCD_NEG = 4'hf;
   localparam logic [2:0] BYTES_ONE = 3'h1;
   localparam logic [2:0] BYTES_TWO = 3'h2;
   localparam logic [2:0] BYTES_FOUR = 3'h4;
   localparam logic [1:0] CODE_ZERO = 2'h0;
   localparam logic [1:0] CODE_LOW = 2'h1;
   localparam logic [1:0] CODE_HIGH = 2'h2;

   typedef enum logic [4:0] {
      OP_NOP, OP_LOAD_B, OP_LOAD_W, OP_LOAD_D, OP_XFER_B, OP_XFER_W, OP_XFER_D,
      OP_AND, OP_OR, OP_ANDN, OP_ORN, OP_AND_OPEN, OP_OR_OPEN, OP_CLOSE, OP_OR_AND,
      OP_ASSIGN, OP_SET, OP_RESET, OP_ADD_FIX, OP_SUB_FIX,
      OP_CMP_EQ, OP_CMP_NE, OP_CMP_GT, OP_CMP_LT, OP_AND_WORD, OP_OR_WORD,
      OP_SHL, OP_SHR, OP_BCD_TO_FIX, OP_FLT_PREP, OP_CLR_STICKY, OP_AUX_LOAD
   } op_type;

   typedef struct packed {
      logic result_code_high;
      logic result_code_low;
      logic range_exceeded_flag;
      logic sticky_range_exceeded;
      logic pending_disjunction;
      logic scanned_status_bit;
      logic logic_result_bit;
      logic first_scan_flag;
   } cc_type;

   typedef struct packed {
      logic pending_disjunction;
      logic logic_result_bit;
      logic and_type;
   } bracket_entry_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
   } bus_phase_type;

endpackage

//--- rtl/plc_accumulator_flags.sv
/*
 * Accumulator, condition code byte and bracket record of a controller
 * instruction datapath, reached as an AHB-Lite slave with zero wait states.
 * Each command executes at the edge that ends its write data phase.
 * Assumes one master issuing single word transfers on one synchronous clock.
 */
// Functional notes
// (RULE1) Primary and secondary 32-bit accumulators are operand sources and result sinks.
// (RULE2) Loads write the primary accumulator; transfers read it.
// (RULE3) Doubleword loads and transfers move all 32 primary bits.
// (RULE4) Byte and word loads clear unused upper bits.
// (RULE5) A load first copies the primary accumulator into the secondary.
// (RULE6) Word access to byte areas uses byte n and byte n+1.
// (RULE7) Transfers leave primary and secondary accumulators unchanged.
// (RULE8) Loads and transfers never touch the third and fourth accumulators.
// (RULE9) Fixed point operands are signed 16-bit, -32768 to +32767.
// (RULE10) BCD layout: sign 15-12, hundreds 11-8, tens 7-4, ones 3-0.
// (RULE11) BCD sign nibble is 0000 positive, 1111 negative.
// (RULE12) Floating point: 8-bit exponent over 24-bit mantissa, 32 bits total.
// (RULE13) Float arithmetic uses 16 mantissa bits; lowest eight forced to zero.
// (RULE14) Condition byte order from bit 7 down as declared in cc_type.
// (RULE15) Memory operations clear first scan, freezing the logic result.
// (RULE16) With first scan clear, next logic op restarts chain from scanned bit.
// (RULE17) Logic result holds bit logic outcome and compare truth.
// (RULE18) Scanned status follows scanned or written bit, except brackets and OR-of-AND.
// (RULE19) Pending disjunction marks AND terms evaluated before a pending OR.
// (RULE20) Range exceeded shows overflow of the last arithmetic operation.
// (RULE21) Sticky range exceeded latches any overflow.
// (RULE22) Result code encodings for arithmetic, word logic, compare and shift.
// (RULE23) Up to 7 bracket levels saving pending OR, logic result and type.
// (RULE24) Sticky overflow cleared only by explicit clear or reset.
`timescale 1ns/1ps
`default_nettype none

module plc_accumulator_flags (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import plc_accu_pkg::*;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Address phase of a taken transfer, kept for its data phase.
   bus_phase_type phase;
   logic [31:0] primary_operand_register, secondary_operand_register, accu3, accu4, operand, xfer_data;
   cc_type cc;
   logic and_term, stored_bit, bracket_error;
   logic [2:0] depth, xfer_bytes;
   bracket_entry_type stack [STACK_DEPTH];

   // A transfer is taken when selected, ready and not idle or busy.
   wire logic take = hsel & hready & htrans[1];
   // Only aligned whole words write; other sizes are dropped.
   wire logic word_ok = (hsize == 3'h2) & (haddr[1:0] == 2'h0);
   wire bus_phase_type next_phase = '{wr: take & hwrite & word_ok, rd: take & ~hwrite, addr: haddr[7:0]};
   // Register writes act one edge after their address phase.
   wire logic wr_cmd = phase.wr & (phase.addr == OFF_CMD);
   wire logic wr_operand = phase.wr & (phase.addr == OFF_OPERAND);
   wire logic wr_status = phase.wr & (phase.addr == OFF_STATUS);
   // A command decodes only in the data phase of its own write.
   // Every other cycle runs as a no-operation.
   wire op_type op = wr_cmd ? op_type'(hwdata[4:0]) : OP_NOP;
   wire logic scan_bit = hwdata[CMD_SCAN_POS];
   wire logic byte_area = hwdata[CMD_BYTE_AREA_POS];
   // Status: depth, chain term, stored bit, error and byte count.
   wire logic [31:0] status_word = {20'h0, xfer_bytes, bracket_error, stored_bit, and_term, 3'h0, depth};

   // Read data follows the address phase and is registered.
   logic [31:0] next_rdata;
   always_comb begin
      unique case (haddr[7:0])
         OFF_CMD: next_rdata = 32'h0;
         OFF_OPERAND: next_rdata = operand;
         OFF_PRIMARY_OPERAND_REGISTER: next_rdata = primary_operand_register;
         OFF_SECONDARY_OPERAND_REGISTER: next_rdata = secondary_operand_register;
         OFF_ACCU3: next_rdata = accu3;
         OFF_ACCU4: next_rdata = accu4;
         OFF_CCB: next_rdata = {24'h0, cc};
         OFF_XFER: next_rdata = xfer_data;
         OFF_STATUS: next_rdata = status_word;
         default: next_rdata = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Operand views
   // ----------------------------------------------------------------
   // Fixed point views are the signed low halves.
   wire logic signed [FIX_W-1:0] fix_a = secondary_operand_register[FIX_W-1:0]; // RULE9
   wire logic signed [FIX_W-1:0] fix_b = primary_operand_register[FIX_W-1:0];
   // One spare bit catches overflow of sums and differences.
   wire logic [FIX_W:0] add_ext = {fix_a[FIX_W-1], fix_a} + {fix_b[FIX_W-1], fix_b};
   wire logic [FIX_W:0] sub_ext = {fix_a[FIX_W-1], fix_a} - {fix_b[FIX_W-1], fix_b};

   // Each BCD digit is weighted in ten bits before summing.
   wire logic [3:0] bcd_sign = primary_operand_register[15:12]; // RULE10
   wire logic [9:0] bcd_mag = 10'(primary_operand_register[11:8]) * 10'd100 + 10'(primary_operand_register[7:4]) * 10'd10 + 10'(primary_operand_register[3:0]);
   wire logic [15:0] bcd_fix = (bcd_sign == BCD_NEG) ? 16'(-{6'h0, bcd_mag}) : {6'h0, bcd_mag}; // RULE11

   // The spare shift bit holds the last bit moved out.
   wire logic [3:0] shift_n = operand[3:0];
   wire logic [16:0] shl_ext = {1'b0, primary_operand_register[15:0]} << shift_n;
   wire logic [16:0] shr_ext = {primary_operand_register[15:0], 1'b0} >> shift_n;

   // Negated scans invert the bit before it joins the chain.
   wire logic scan_val = scan_bit ^ ((op == OP_ANDN) | (op == OP_ORN));
   // An empty bracket record reads as zero.
   wire bracket_entry_type top = (depth == 3'h0) ? '0 : stack[depth - 3'h1];
   // A push past seven levels is refused and flagged.
   wire logic push_ok = depth < 3'(STACK_DEPTH);

   // Sign code of a result: zero, negative or positive.
   function automatic logic [1:0] sign_code(input logic [15:0] v);
      sign_code = (v == 16'h0) ? CODE_ZERO : (v[15] ? CODE_LOW : CODE_HIGH);
   endfunction

   // ----------------------------------------------------------------
   // Instruction execution
   // ----------------------------------------------------------------
   // Next values of the datapath registers other than accu4, operand and the bracket record.
   logic [31:0] next_primary_operand_register, next_secondary_operand_register, next_accu3, next_xfer;
   logic [2:0] next_xfer_bytes, next_depth;
   cc_type next_cc;
   logic next_term, next_stored, push, next_berr;
   logic [15:0] fix_res;
   logic ovf, cmp_true;

   // Registers hold unless the decoded command changes them; a status write with bit 4 set also clears the bracket error.
   always_comb begin
      next_primary_operand_register = primary_operand_register;
      next_secondary_operand_register = secondary_operand_register;
      next_accu3 = accu3;
      next_xfer = xfer_data;
      next_xfer_bytes = xfer_bytes;
      next_cc = cc;
      next_term = and_term;
      next_stored = stored_bit;
      next_depth = depth;
      next_berr = bracket_error & ~(wr_status & hwdata[4]);
      push = 1'b0;
      fix_res = 16'h0;
      ovf = 1'b0;
      cmp_true = 1'b0;
      unique case (op)
         OP_NOP: ;

         // Loads push the old primary value into the secondary.
         OP_LOAD_B, OP_LOAD_W, OP_LOAD_D: begin
            next_secondary_operand_register = primary_operand_register; // RULE5 RULE8
            next_primary_operand_register = (op == OP_LOAD_B) ? {24'h0, operand[7:0]} : // RULE2 RULE4
               (op == OP_LOAD_W) ? {16'h0, operand[15:0]} : operand; // RULE3
            next_xfer_bytes = (op == OP_LOAD_D) ? BYTES_FOUR :
               ((op == OP_LOAD_W) & byte_area) ? BYTES_TWO : BYTES_ONE; // RULE6
         end

         // Transfers fill only the transfer register and the byte count.
         OP_XFER_B, OP_XFER_W, OP_XFER_D: begin
            next_xfer = (op == OP_XFER_B) ? {24'h0, primary_operand_register[7:0]} : // RULE7
               (op == OP_XFER_W) ? {16'h0, primary_operand_register[15:0]} : primary_operand_register; // RULE3
            next_xfer_bytes = (op == OP_XFER_D) ? BYTES_FOUR :
               ((op == OP_XFER_W) & byte_area) ? BYTES_TWO : BYTES_ONE; // RULE6
         end

         // A cleared first scan flag starts a fresh chain.
         OP_AND, OP_ANDN, OP_OR, OP_ORN: begin
            next_cc.scanned_status_bit = scan_bit; // RULE18
            next_cc.first_scan_flag = 1'b1;
            if (!cc.first_scan_flag) begin
               next_term = scan_val; // RULE16
               next_cc.logic_result_bit = cc.pending_disjunction | scan_val;
            end else if ((op == OP_AND) | (op == OP_ANDN)) begin
               next_term = and_term & scan_val; // RULE19
               next_cc.logic_result_bit = cc.pending_disjunction | (and_term & scan_val); // RULE17
            end else begin
               next_cc.logic_result_bit = cc.logic_result_bit | scan_val;
               next_term = cc.logic_result_bit | scan_val;
               next_cc.pending_disjunction = 1'b0;
            end
         end

         // The parked result is ORed into the next AND term.
         OP_OR_AND: begin
            next_cc.pending_disjunction = cc.logic_result_bit; // RULE19
            next_cc.first_scan_flag = 1'b0;
         end

         // Opening saves the chain state in the next free slot.
         OP_AND_OPEN, OP_OR_OPEN: begin
            if (push_ok) begin
               push = 1'b1; // RULE23
               next_depth = depth + 3'h1;
               next_cc.first_scan_flag = 1'b0;
               next_cc.pending_disjunction = 1'b0;
            end else begin
               next_berr = 1'b1;
            end
         end

         // Closing merges the inner result with the saved one.
         OP_CLOSE: begin
            if (depth != 3'h0) begin
               next_depth = depth - 3'h1; // RULE23
               next_cc.logic_result_bit = top.and_type ? (top.logic_result_bit & cc.logic_result_bit) :
                  (top.logic_result_bit | cc.logic_result_bit);
               next_cc.pending_disjunction = top.pending_disjunction;
               next_term = next_cc.logic_result_bit;
               next_cc.first_scan_flag = 1'b1;
            end else begin
               next_berr = 1'b1;
            end
         end

         // Memory operations end the chain and freeze the result.
         OP_ASSIGN, OP_SET, OP_RESET: begin
            if (op == OP_ASSIGN) begin
               next_stored = cc.logic_result_bit;
            end else if (cc.logic_result_bit) begin
               next_stored = (op == OP_SET);
            end
            next_cc.scanned_status_bit = next_stored; // RULE18
            next_cc.first_scan_flag = 1'b0; // RULE15
            next_cc.pending_disjunction = 1'b0;
         end

         // Fixed point results are sign-extended into the primary.
         OP_ADD_FIX, OP_SUB_FIX: begin
            fix_res = (op == OP_ADD_FIX) ? add_ext[FIX_W-1:0] : sub_ext[FIX_W-1:0];
            ovf = (op == OP_ADD_FIX) ? (add_ext[FIX_W] != add_ext[FIX_W-1]) :
               (sub_ext[FIX_W] != sub_ext[FIX_W-1]);
            next_primary_operand_register = {{16{fix_res[15]}}, fix_res};
            next_cc.range_exceeded_flag = ovf; // RULE20
            next_cc.sticky_range_exceeded = cc.sticky_range_exceeded | ovf; // RULE21 RULE24
            {next_cc.result_code_high, next_cc.result_code_low} = sign_code(fix_res); // RULE22
         end

         // Compares give truth in the result and order in the code.
         OP_CMP_EQ, OP_CMP_NE, OP_CMP_GT, OP_CMP_LT: begin
            unique case (op)
               OP_CMP_EQ: cmp_true = fix_a == fix_b;
               OP_CMP_NE: cmp_true = fix_a != fix_b;
               OP_CMP_GT: cmp_true = fix_a > fix_b;
               default: cmp_true = fix_a < fix_b;
            endcase
            next_cc.logic_result_bit = cmp_true; // RULE17
            next_cc.first_scan_flag = 1'b0;
            {next_cc.result_code_high, next_cc.result_code_low} = (fix_a == fix_b) ? CODE_ZERO :
               ((fix_a < fix_b) ? CODE_LOW : CODE_HIGH); // RULE22
         end

         // Word logic works on the low halves only.
         OP_AND_WORD, OP_OR_WORD: begin
            fix_res = (op == OP_AND_WORD) ? (primary_operand_register[15:0] & secondary_operand_register[15:0]) : (primary_operand_register[15:0] | secondary_operand_register[15:0]);
            next_primary_operand_register = {16'h0, fix_res};
            {next_cc.result_code_high, next_cc.result_code_low} = (fix_res == 16'h0) ? CODE_ZERO :
               CODE_HIGH; // RULE22
         end

         // A zero count leaves the result code as it was.
         OP_SHL, OP_SHR: begin
            fix_res = (op == OP_SHL) ? shl_ext[15:0] : shr_ext[16:1];
            next_primary_operand_register = {16'h0, fix_res};
            if (shift_n != 4'h0) begin
               next_cc.result_code_high = (op == OP_SHL) ? shl_ext[16] : shr_ext[0]; // RULE22
               next_cc.result_code_low = 1'b0;
            end
         end

         // The sign nibble decides whether the value is negated.
         OP_BCD_TO_FIX: next_primary_operand_register = {{16{bcd_fix[15]}}, bcd_fix};

         // Only sixteen mantissa bits take part in float arithmetic.
         OP_FLT_PREP: begin
            next_primary_operand_register = primary_operand_register & MANT_TRUNC_MASK; // RULE12 RULE13
            next_secondary_operand_register = secondary_operand_register & MANT_TRUNC_MASK;
         end

         // The sticky flag falls only here or on reset.
         OP_CLR_STICKY: next_cc.sticky_range_exceeded = 1'b0; // RULE24

         // The auxiliary pair moves up by one register.
         OP_AUX_LOAD: next_accu3 = primary_operand_register;
      endcase
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   // The slave holds hreadyout low only in reset, inserts no wait states after it and always answers OKAY.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= '0;
         hrdata <= 32'h0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         phase <= next_phase;
         hrdata <= (take & ~hwrite) ? next_rdata : 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Accumulators, operand and transfer result.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         primary_operand_register <= ACC_RESET; // RULE1
         secondary_operand_register <= ACC_RESET;
         accu3 <= ACC_RESET;
         accu4 <= ACC_RESET;
         operand <= ACC_RESET;
         xfer_data <= ACC_RESET;
      end else begin
         primary_operand_register <= next_primary_operand_register;
         secondary_operand_register <= next_secondary_operand_register;
         accu3 <= next_accu3;
         accu4 <= op == OP_AUX_LOAD ? accu3 : accu4;
         xfer_data <= next_xfer;
         if (wr_operand) begin
            operand <= hwdata;
         end
      end
   end

   // Condition byte and chain state.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cc <= cc_type'(CC_RESET); // RULE14
         and_term <= 1'b0;
         stored_bit <= 1'b0;
         depth <= 3'h0;
         bracket_error <= 1'b0;
         xfer_bytes <= BYTES_ONE;
      end else begin
         cc <= next_cc;
         and_term <= next_term;
         stored_bit <= next_stored;
         depth <= next_depth;
         bracket_error <= next_berr;
         xfer_bytes <= next_xfer_bytes;
      end
   end

   // ----------------------------------------------------------------
   // Bracket record, one slot per level
   // ----------------------------------------------------------------
   // A slot is written only when a bracket opens at its depth.
   for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            stack[i] <= '0;
         end else if (push && depth == 3'(i)) begin
            stack[i] <= '{pending_disjunction: cc.pending_disjunction, // RULE23
                          logic_result_bit: cc.logic_result_bit,
                          and_type: op == OP_AND_OPEN};
         end
      end
   end

endmodule

`default_nettype wire

//--- test/plc_accu_properties.sv
/*
 * Checker of the register port of the accumulator datapath.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module plc_accu_props
   import plc_accu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   logic rd_q;
   logic [7:0] a_q;
   wire logic rd_take = hsel & hready & htrans[1] & ~hwrite;
   wire logic ccb_rd = rd_q && (a_q == OFF_CCB);
   wire logic sts_rd = rd_q && (a_q == OFF_STATUS);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_q <= 1'b0;
         a_q <= 8'h00;
      end else begin
         rd_q <= rd_take;
         a_q <= haddr[7:0];
      end
   end

   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
   a_ready_held: assert property ($past(nrst) |-> hreadyout) else $error("wait state seen");
   a_idle_zero: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not zero");
   a_cmd_zero: assert property (rd_q && a_q == OFF_CMD |-> hrdata == 32'h0) else $error("command reads back");
   a_unmapped_zero: assert property (rd_q && a_q >= 8'h24 |-> hrdata == 32'h0) else $error("unmapped not zero");
   a_ccb_width: assert property (ccb_rd |-> hrdata[31:8] == 24'h0) else $error("flag byte too wide");
   a_code_legal: assert property (ccb_rd |-> hrdata[7:6] != 2'h3) else $error("result code 11");
   a_sticky_latch: assert property (ccb_rd && hrdata[5] |-> hrdata[4]) else $error("sticky missed");
   a_bytes_legal: assert property (sts_rd |-> hrdata[11:9] inside {3'h1, 3'h2, 3'h4}) else $error("byte count");

   c_overflow: cover property (ccb_rd && hrdata[5]);
   c_negative: cover property (ccb_rd && hrdata[7:6] == 2'h1);
   c_bracket_err: cover property (sts_rd && hrdata[8]);
endmodule

bind plc_accumulator_flags plc_accu_props i_props (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hready, .hwdata, .hrdata, .hreadyout, .hresp);

`default_nettype wire

//--- test/test_plc_accumulator_flags.sv
/*
 * Self-checking bench of the accumulator datapath over AHB-Lite.
 * Assumes the slave's hreadyout is the bus hready and one master.
 */
`timescale 1ns/1ps
`default_nettype none

module test_plc_accumulator_flags;
   import plc_accu_pkg::*;
   logic clk, nrst, hsel, hwrite;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic [31:0] hrdata;
   wire logic hready, hresp;
   int err_count, num_checks;

   plc_accumulator_flags i_dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
      .hwdata, .hrdata, .hreadyout(hready), .hresp);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----
   // Bus tasks
   // ----
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      // Waits end only on hready; a stalled bus is left to the watchdog.
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      num_checks++;
      if ((q & m) !== e) begin
         err_count++;
         $display("FAIL t=%0t addr %h got %h want %h", $time, a, q & m, e);
      end
   endtask

   task op(input op_type o, input logic s = 1'b0, input logic b = 1'b0);
      wr(OFF_CMD, {22'h0, b, s, 3'h0, o});
   endtask

   task ld(input logic [31:0] v, input op_type o = OP_LOAD_D);
      wr(OFF_OPERAND, v);
      op(o);
   endtask

   // ----
   // Scenarios
   // ----
   task t_reset;
      for (int i = 2; i < 6; i++) rc(8'(4 * i), 32'h0);
      rc(OFF_CCB, {24'h0, CC_RESET});
      rc(OFF_STATUS, 32'h0000_0200);
      wr(OFF_CCB, 32'hffff_ffff);
      rc(OFF_CCB, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rc(8'h40, 32'h0);
   endtask

   task t_load;
      ld(32'h1234_5678);
      rc(OFF_OPERAND, 32'h1234_5678);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h1234_5678);
      ld(32'haabb_ccdd, OP_LOAD_B);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h0000_00dd);
      rc(OFF_SECONDARY_OPERAND_REGISTER, 32'h1234_5678);
      ld(32'haabb_ccdd, OP_LOAD_W);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h0000_ccdd);
      op(OP_XFER_D);
      rc(OFF_XFER, 32'h0000_ccdd);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h0000_ccdd);
      rc(OFF_SECONDARY_OPERAND_REGISTER, 32'h0000_00dd);
      ld(32'h8765_4321);
      op(OP_XFER_B);
      rc(OFF_XFER, 32'h0000_0021);
      op(OP_XFER_W, 1'b0, 1'b1);
      rc(OFF_XFER, 32'h0000_4321);
      rc(OFF_STATUS, 32'h0000_0400, 32'h0000_0e00);
      op(OP_AUX_LOAD);
      ld(32'h1);
      op(OP_AUX_LOAD);
      ld(32'h2, OP_LOAD_B);
      op(OP_XFER_D);
      rc(OFF_ACCU3, 32'h1);
      rc(OFF_ACCU4, 32'h8765_4321);
   endtask

   task t_logic;
      op(OP_ASSIGN);
      rc(OFF_CCB, 32'h0, 32'h7);
      op(OP_AND, 1'b1);
      rc(OFF_CCB, 32'h7, 32'h7);
      op(OP_AND, 1'b1);
      rc(OFF_CCB, 32'h7, 32'h7);
      op(OP_AND, 1'b0);
      rc(OFF_CCB, 32'h1, 32'h7);
      op(OP_ASSIGN);
      rc(OFF_CCB, 32'h0, 32'h7);
      op(OP_ORN, 1'b0);
      rc(OFF_CCB, 32'h3, 32'h7);
      op(OP_OR_AND);
      rc(OFF_CCB, 32'h8, 32'h9);
      op(OP_AND, 1'b0);
      rc(OFF_CCB, 32'hb, 32'hf);
      op(OP_OR, 1'b0);
      rc(OFF_CCB, 32'h3, 32'hf);
      op(OP_SET);
      rc(OFF_CCB, 32'h6, 32'hf);
      rc(OFF_STATUS, 32'h80, 32'h80);
      op(OP_AND, 1'b0);
      op(OP_RESET);
      rc(OFF_STATUS, 32'h80, 32'h80);
      rc(OFF_CCB, 32'h4, 32'hf);
      op(OP_AND, 1'b1);
      op(OP_RESET);
      rc(OFF_STATUS, 32'h0, 32'h80);
      rc(OFF_CCB, 32'h2, 32'hf);
   endtask

   task t_arith;
      ld(32'h7fff);
      ld(32'h1);
      op(OP_ADD_FIX);
      rc(OFF_CCB, 32'h30, 32'h30);
      ld(32'h8000);
      ld(32'hffff);
      op(OP_SUB_FIX);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'hffff_8001);
      rc(OFF_CCB, 32'h50, 32'hf0);
      ld(32'h3);
      ld(32'h2);
      op(OP_ADD_FIX);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h5);
      rc(OFF_CCB, 32'h90, 32'hf0);
      op(OP_CLR_STICKY);
      rc(OFF_CCB, 32'h0, 32'h30);
   endtask

   task t_cmp;
      ld(32'h5);
      ld(32'h3);
      op(OP_CMP_GT);
      rc(OFF_CCB, 32'h82, 32'hc2);
      op(OP_CMP_EQ);
      rc(OFF_CCB, 32'h80, 32'hc2);
      ld(32'h3);
      op(OP_CMP_EQ);
      rc(OFF_CCB, 32'h02, 32'hc2);
      ld(32'h9);
      op(OP_CMP_LT);
      rc(OFF_CCB, 32'h42, 32'hc2);
      op(OP_CMP_NE);
      rc(OFF_CCB, 32'h42, 32'hc2);
   endtask

   task t_word;
      ld(32'hf0);
      ld(32'h0f);
      op(OP_AND_WORD);
      rc(OFF_CCB, 32'h0, 32'hc0);
      op(OP_OR_WORD);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'hf0);
      rc(OFF_CCB, 32'h80, 32'hc0);
      ld(32'h3);
      wr(OFF_OPERAND, 32'h1);
      op(OP_SHR);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h1);
      rc(OFF_CCB, 32'h80, 32'hc0);
      op(OP_SHR);
      op(OP_SHL);
      rc(OFF_CCB, 32'h0, 32'hc0);
   endtask

   task t_fmt;
      ld(32'hf123);
      op(OP_BCD_TO_FIX);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'hffff_ff85);
      ld(32'h0456);
      op(OP_BCD_TO_FIX);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h1c8);
      ld(32'h4112_3456);
      ld(32'h8abc_def1);
      op(OP_FLT_PREP);
      rc(OFF_PRIMARY_OPERAND_REGISTER, 32'h8abc_de00);
      rc(OFF_SECONDARY_OPERAND_REGISTER, 32'h4112_3400);
   endtask

   task t_brk;
      repeat (7) op(OP_AND_OPEN);
      rc(OFF_STATUS, 32'h7, 32'h107);
      op(OP_OR_OPEN);
      rc(OFF_STATUS, 32'h107, 32'h107);
      repeat (7) op(OP_CLOSE);
      wr(OFF_STATUS, 32'h10);
      rc(OFF_STATUS, 32'h0, 32'h107);
      op(OP_ASSIGN);
      op(OP_AND, 1'b1);
      op(OP_AND_OPEN);
      op(OP_AND, 1'b0);
      op(OP_CLOSE);
      rc(OFF_CCB, 32'h1, 32'hb);
      op(OP_OR_OPEN);
      op(OP_AND, 1'b1);
      op(OP_CLOSE);
      rc(OFF_CCB, 32'h3, 32'hb);
      rc(OFF_STATUS, 32'h0, 32'h7);
   endtask

   task results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      results;
   end

   initial begin
      {nrst, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      err_count = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      hsel <= 1'b1;
      t_reset;
      t_load;
      t_logic;
      t_arith;
      t_cmp;
      t_word;
      t_fmt;
      t_brk;
      results;
   end
endmodule

`default_nettype wire
